/* hw/spp_pkg.sv */
// Purpose: Shared constants and types for the serial PROM port control block.
// Assumes: Byte-wide control register behind a 32-bit classic Wishbone slave.
// Notes: Register index printed as 0x1e; byte address is four times the index.
package spp_pkg;
    localparam logic [7:0] SPP_CTRL_INDEX = 8'h1e;
    localparam logic [9:0] SPP_CTRL_ADDR = {SPP_CTRL_INDEX, 2'b00};
    localparam int SPP_ADDR_W = 10;
    localparam int BIT_GRANT = 7;
    localparam int BIT_REQUEST = 6;
    localparam int BIT_MODE = 5;
    localparam int BIT_READY = 4;
    localparam int BIT_CS = 3;
    localparam int BIT_CLK = 2;
    localparam int BIT_DOUT = 1;
    localparam int BIT_DIN = 0;
    localparam int LINE_CLK = 2;
    localparam int LINE_DOUT = 1;
    localparam int LINE_DIN = 0;
    // Pacing time in ns and the clock period in ps.
    localparam int SPP_PACE_NS = 800;
    localparam int SPP_CLK_PS = 5000;
    localparam int SPP_PACE_CYC = (SPP_PACE_NS * 1000 + SPP_CLK_PS - 1) / SPP_CLK_PS;
    localparam int SPP_CNT_W = 8;

    // Arbitration states of the port.
    typedef enum logic [1:0]
    {
        ARB_IDLE = 2'b00,
        ARB_WAIT = 2'b01,
        ARB_OWN = 2'b10
    } spp_arb_t;

    // Software-writable control fields.
    typedef struct packed
    {
        logic mode;
        logic cs;
        logic clk;
        logic dout;
    } spp_ctrl_t;

    // Whole state of the block.
    typedef struct packed
    {
        spp_ctrl_t ctrl;
        spp_arb_t arb;
        logic ready;
        logic [SPP_CNT_W-1:0] pace;
        logic [1:0] grant_sync;
        logic [1:0] din_sync;
        logic ack;
        logic [31:0] rdata;
    } spp_state_t;
endpackage

/* hw/spp_port_ctrl.sv */
// Purpose: Software-driven control of a 4-wire serial PROM on a shared memory port.
// Assumes: One clock sys_clk at 200 MHz, synchronous active-low reset rstn.
// Notes: Grant and data-in pins are synchronised by two flip-flops before use.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
module spp_port_ctrl
    import spp_pkg::*;
#(
    parameter int PACE_CYC = SPP_PACE_CYC
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Classic Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [SPP_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Memory port arbitration.
    input wire logic memport_busy,
    input wire logic port_grant_n,
    output logic port_request_n,
    // Memory port lines and chip select.
    input wire logic [2:0] port_data_lines_i,
    output logic [2:0] port_data_lines_o,
    output logic [2:0] port_data_lines_oe,
    output logic prom_chip_select,
    output logic prom_chip_select_oe
);
    spp_state_t st;
    spp_state_t next_st;
    logic req;
    logic wr_hit;
    logic owned;
    logic [7:0] rd_byte;

    localparam logic [SPP_CNT_W-1:0] PACE_LOAD = SPP_CNT_W'(PACE_CYC);

    // Address decode shared by the write strobe, the read image and the checks.
    // Only the one control register is mapped; every other address reads zero.
    function automatic logic ctrl_hit(input logic [SPP_ADDR_W-1:0] adr);
        return adr == SPP_CTRL_ADDR;
    endfunction

    // Request is asserted while software wants the port and it is free or already won.
    always_comb
    begin
        req = st.ctrl.mode && (st.arb != ARB_IDLE);
        // Clearing the mode bit releases the pins at once, so chip select never
        // outlives the mode bit for the cycle the arbiter needs to go idle.
        owned = (st.arb == ARB_OWN) && st.ctrl.mode;
        wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack && wb_sel_i[0]
                 && ctrl_hit(wb_adr_i);
    end

    // Read image; the request bit reports the pin level, not the intent.
    always_comb
    begin
        rd_byte = 8'h00;
        rd_byte[BIT_GRANT] = st.grant_sync[1];
        rd_byte[BIT_REQUEST] = !req;
        rd_byte[BIT_MODE] = st.ctrl.mode;
        rd_byte[BIT_READY] = st.ready;
        rd_byte[BIT_CS] = st.ctrl.cs;
        rd_byte[BIT_CLK] = st.ctrl.clk;
        rd_byte[BIT_DOUT] = st.ctrl.dout;
        rd_byte[BIT_DIN] = st.ctrl.mode ? st.din_sync[1] : 1'b0;
    end

    // Next-state logic for bus, arbitration and pacing timer.
    always_comb
    begin
        next_st = st;
        next_st.grant_sync = {st.grant_sync[0], port_grant_n};
        next_st.din_sync = {st.din_sync[0], port_data_lines_i[LINE_DIN]};
        // Single-cycle ack; dropped the cycle after it was given.
        next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
        next_st.rdata = 32'h0000_0000;
        if (wb_cyc_i && wb_stb_i && !st.ack && ctrl_hit(wb_adr_i))
        begin
            next_st.rdata = {24'h00_0000, rd_byte};
        end
        // Pacing timer counts down, ready rises when it expires.
        if (st.pace != '0)
        begin
            next_st.pace = st.pace - 1'b1;
        end
        if (st.pace == SPP_CNT_W'(1) && !(st.ctrl.mode && !owned))
        begin
            next_st.ready = 1'b1;
        end
        // Arbitration: wait for a free port, then for grant, then hold.
        unique case (st.arb)
            ARB_IDLE:
            begin
                if (st.ctrl.mode && !memport_busy)
                begin
                    next_st.arb = ARB_WAIT;
                end
            end
            ARB_WAIT:
            begin
                if (!st.ctrl.mode)
                begin
                    next_st.arb = ARB_IDLE;
                end
                else if (!st.grant_sync[1])
                begin
                    next_st.arb = ARB_OWN;
                    next_st.ready = 1'b1;
                end
            end
            ARB_OWN:
            begin
                if (!st.ctrl.mode)
                begin
                    next_st.arb = ARB_IDLE;
                end
            end
            default:
            begin
                next_st.arb = ARB_IDLE;
            end
        endcase
        // A write stores the writable bits only and restarts the timer, or stops it when it sets the mode bit before the port is owned.
        if (wr_hit)
        begin
            next_st.ctrl.mode = wb_dat_i[BIT_MODE];
            next_st.ctrl.cs = wb_dat_i[BIT_CS];
            next_st.ctrl.clk = wb_dat_i[BIT_CLK];
            next_st.ctrl.dout = wb_dat_i[BIT_DOUT];
            next_st.ready = 1'b0;
            next_st.pace = PACE_LOAD;
            // A grant landing in the same cycle counts as owned, otherwise the
            // timer would be killed and ready would never return.
            if (wb_dat_i[BIT_MODE] && next_st.arb != ARB_OWN)
            begin
                next_st.pace = '0;
            end
        end
    end

    // State register; idle grant is taken as released until the pin is seen.
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.arb <= ARB_IDLE;
            st.grant_sync <= 2'b11;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Port drive only once arbitration is complete.
    always_comb
    begin
        port_request_n = !req;
        wb_ack_o = st.ack;
        wb_dat_o = st.rdata;
        port_data_lines_oe = owned ? 3'b110 : 3'b000;
        port_data_lines_o = 3'b000;
        port_data_lines_o[LINE_CLK] = owned && st.ctrl.clk;
        port_data_lines_o[LINE_DOUT] = owned && st.ctrl.dout;
        prom_chip_select_oe = owned;
        prom_chip_select = owned && st.ctrl.cs;
    end

    // Cycle counter of the pacing window for checking its length.
    int unsigned pace_seen;
    always_ff @(posedge sys_clk)
    begin
        if (!rstn || wr_hit)
        begin
            pace_seen <= 0;
        end
        else if (pace_seen < 100000)
        begin
            pace_seen <= pace_seen + 1;
        end
    end

    // Checks tie the pins and the read image back to what the bus wrote, so a
    // broken gate shows up as a wrong pin level rather than a silent pass.

    // Request falls one cycle after the mode bit meets a free port.
    AST_REQ_FOLLOWS_MODE: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st.arb == ARB_IDLE && st.ctrl.mode && next_st.ctrl.mode && !memport_busy)
        |=> !port_request_n)
        else $error("request not asserted after mode set");

    // A busy port keeps the request released.
    AST_BUSY_HOLDS: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st.arb == ARB_IDLE && memport_busy) |=> port_request_n)
        else $error("request raised while port busy");

    // The synchronised grant hands the lines to the register bits.
    AST_GRANT_OWNS: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st.arb == ARB_WAIT && st.ctrl.mode && next_st.ctrl.mode && !st.grant_sync[1])
        |=> (port_data_lines_oe == 3'b110 && prom_chip_select_oe))
        else $error("port not taken after grant");

    // Ownership stays for as long as the mode bit stays.
    AST_HOLD_OWN: assert property (@(posedge sys_clk) disable iff (!rstn)
        owned |=> (owned || !st.ctrl.mode))
        else $error("ownership dropped while mode set");

    // Clearing the mode bit gives the request back in the next cycle.
    AST_REQ_DROPS: assert property (@(posedge sys_clk) disable iff (!rstn)
        !next_st.ctrl.mode |=> port_request_n)
        else $error("request held after mode cleared");

    // Any register write with byte lane 0 clears ready.
    AST_WRITE_CLEARS: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_hit |=> !st.ready)
        else $error("ready not cleared by write");

    // The pacing window ends exactly PACE_CYC cycles after the write.
    AST_READY_TIME: assert property (@(posedge sys_clk) disable iff (!rstn)
        ($rose(st.ready) && !owned) |-> (pace_seen == PACE_CYC))
        else $error("ready rose at wrong time");

    // No ready while the port is requested but not yet granted.
    AST_NO_READY_UNGRANTED: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st.ctrl.mode && st.arb != ARB_OWN) |-> !st.ready)
        else $error("ready high before grant");

    // Ready answers the grant itself, not the timer.
    AST_READY_ON_GRANT: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st.arb == ARB_WAIT && st.ctrl.mode && !st.grant_sync[1] && !wr_hit) |=> st.ready)
        else $error("ready not set by grant");

    // Outputs float until the port is owned.
    AST_UNDRIVEN: assert property (@(posedge sys_clk) disable iff (!rstn)
        !owned |-> (port_data_lines_oe == 3'b000 && !prom_chip_select_oe))
        else $error("port driven without grant");

    // Bit 7 returns the synchronised grant pin.
    AST_GRANT_READBACK: assert property (@(posedge sys_clk) disable iff (!rstn)
        (next_st.ack && ctrl_hit(wb_adr_i))
        |=> (wb_dat_o[BIT_GRANT] == $past(st.grant_sync[1])))
        else $error("grant bit readback wrong");

    // Bit 6 returns the request pin level.
    AST_REQ_READBACK: assert property (@(posedge sys_clk) disable iff (!rstn)
        (next_st.ack && ctrl_hit(wb_adr_i))
        |=> (wb_dat_o[BIT_REQUEST] == $past(port_request_n)))
        else $error("request bit readback wrong");

    // Chip select needs the mode bit, ownership and the register bit.
    AST_CS_GATED: assert property (@(posedge sys_clk) disable iff (!rstn)
        prom_chip_select |-> (st.ctrl.mode && owned && st.ctrl.cs))
        else $error("chip select without ownership");

    // A write while owned puts the written clock bit on its line.
    AST_CLK_LINE: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_hit && owned && wb_dat_i[BIT_MODE])
        |=> (port_data_lines_o[LINE_CLK] == $past(wb_dat_i[BIT_CLK])))
        else $error("clock line does not follow write");

    // A write while owned puts the written data bit on its line.
    AST_DOUT_LINE: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_hit && owned && wb_dat_i[BIT_MODE])
        |=> (port_data_lines_o[LINE_DOUT] == $past(wb_dat_i[BIT_DOUT])))
        else $error("data line does not follow write");

    // Without the mode bit the data-in bit reads zero.
    AST_DIN_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
        (next_st.ack && ctrl_hit(wb_adr_i) && !st.ctrl.mode) |=> !wb_dat_o[BIT_DIN])
        else $error("data in visible without mode");

    // A write that leaves the mode bit low reloads the pacing timer.
    AST_TIMER_RESTART: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_hit && !wb_dat_i[BIT_MODE]) |=> (st.pace == PACE_LOAD && !st.ready))
        else $error("write did not restart the timer");

    // Main scenarios: grant, pacing expiry and release.
    COV_GRANT: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(owned));
    COV_PACE: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(st.ready) && !owned);
    COV_RELEASE: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(owned));
    // A request held back by a busy port, and a shift clock edge on the pin.
    COV_BUSY_HOLD: cover property (@(posedge sys_clk) disable iff (!rstn)
        st.ctrl.mode && memport_busy && st.arb == ARB_IDLE);
    COV_SHIFT_CLOCK: cover property (@(posedge sys_clk) disable iff (!rstn)
        $rose(port_data_lines_o[LINE_CLK]));
endmodule

/* tb/spp_prom_model.sv */
// Purpose: Far-side model, a port arbiter plus a 4-wire serial PROM.
// Assumes: The arbiter grants 21 cycles after the request falls.
// Notes: Undriven lines toggle every cycle so stale values never look valid.
`timescale 1ns/10ps
module spp_prom_model
(
    // Clock.
    input wire logic sys_clk,
    // Arbitration pins.
    input wire logic port_request_n,
    output logic port_grant_n,
    // Port lines and chip select.
    input wire logic [2:0] lines_o,
    input wire logic [2:0] lines_oe,
    input wire logic chip_select,
    input wire logic chip_select_oe,
    output logic [2:0] lines_i
);
    logic [4:0] wait_cnt = 5'h00;
    logic gnt_n = 1'b1;
    logic prom_q = 1'b0;
    logic last_clk = 1'b0;
    logic noise = 1'b0;
    wire logic sel_on = chip_select & chip_select_oe;

    // Slow grant so the pacing timeout passes first; held until the request drops.
    always @(posedge sys_clk)
    begin
        noise <= ~noise;
        last_clk <= lines_o[2] & lines_oe[2];
        if (port_request_n)
        begin
            wait_cnt <= 5'h00;
            gnt_n <= 1'b1;
        end
        else if (wait_cnt == 5'h14)
            gnt_n <= 1'b0;
        else
            wait_cnt <= wait_cnt + 5'h01;
        // The PROM echoes the data bit taken at each shift clock rise.
        if (sel_on && lines_oe[2] && lines_o[2] && !last_clk)
            prom_q <= lines_o[1];
    end

    // The gnt_n register keeps the grant pin high while the arbiter is idle.
    assign port_grant_n = gnt_n;
    assign lines_i[2] = lines_oe[2] ? lines_o[2] : noise;
    assign lines_i[1] = lines_oe[1] ? lines_o[1] : ~noise;
    assign lines_i[0] = lines_oe[0] ? lines_o[0] : (sel_on ? prom_q : noise);
endmodule

/* tb/tb_spp_port_ctrl.sv */
// Purpose: Register-level bench for the serial PROM port control block.
// Assumes: Pacing shortened to 8 cycles; one register at SPP_CTRL_ADDR.
// Notes: Every access is a classic Wishbone cycle waiting for ack.
`timescale 1ns/10ps
module tb_spp_port_ctrl;
    import spp_pkg::*;
    localparam int PC = 8;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic busy = 1'b0;
    logic [SPP_ADDR_W-1:0] adr = '0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic byte0_en = 1'b1;
    logic [31:0] dato;
    logic [31:0] rd;
    logic ack, req_n, gnt_n, cs, cs_oe;
    logic [2:0] li, lo, loe;
    int bad_count = 0;
    int check_count = 0;

    // Free-running 200 MHz clock.
    always #2.5 sys_clk = ~sys_clk;

    spp_port_ctrl #(.PACE_CYC(PC)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dato), .wb_ack_o(ack), .memport_busy(busy), .port_grant_n(gnt_n),
        .port_request_n(req_n), .port_data_lines_i(li), .port_data_lines_o(lo),
        .port_data_lines_oe(loe), .prom_chip_select(cs), .prom_chip_select_oe(cs_oe));
    spp_prom_model u_prom (.sys_clk(sys_clk), .port_request_n(req_n),
        .port_grant_n(gnt_n), .lines_o(lo), .lines_oe(loe), .chip_select(cs),
        .chip_select_oe(cs_oe), .lines_i(li));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; the request is held until ack is sampled high or 20 cycles pass.
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= {3'b000, byte0_en};
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20)
            chk(32'h1, 32'h0);
    endtask

    task automatic rdchk(input logic [7:0] exp);
        xfer(1'b0, SPP_CTRL_ADDR, 8'h00);
        chk(rd, {24'h0, exp});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // A hang ends the run as a failure.
    initial
    begin
        #100000;
        bad_count++;
        results();
    end

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        rdchk(8'hc0);
        xfer(1'b1, SPP_CTRL_ADDR, 8'h00);
        repeat (PC + 4) @(posedge sys_clk);
        rdchk(8'hd0);
        xfer(1'b1, SPP_CTRL_ADDR, 8'h00);
        rdchk(8'hc0);
        // A busy port must not raise the request.
        busy <= 1'b1;
        xfer(1'b1, SPP_CTRL_ADDR, 8'h20);
        repeat (30) @(posedge sys_clk);
        chk(req_n, 1'b1);
        chk(loe, 3'b000);
        xfer(1'b1, SPP_CTRL_ADDR, 8'h00);
        busy <= 1'b0;
        repeat (PC + 4) @(posedge sys_clk);
        // Request with a slow grant: ready waits past the timeout.
        xfer(1'b1, SPP_CTRL_ADDR, 8'h20);
        repeat (PC + 4) @(posedge sys_clk);
        rdchk(8'ha0);
        chk({cs_oe, loe}, 4'h0);
        for (int i = 0; i < 40 && rd[4] !== 1'b1; i++)
            xfer(1'b0, SPP_CTRL_ADDR, 8'h00);
        chk(rd, 32'h30);
        chk({cs_oe, loe}, 4'he);
        xfer(1'b1, SPP_CTRL_ADDR, 8'h2e);
        repeat (2) @(posedge sys_clk);
        chk({cs, lo[2:1]}, 3'b111);
        repeat (16) @(posedge sys_clk);
        xfer(1'b1, SPP_CTRL_ADDR, 8'h2a);
        repeat (2) @(posedge sys_clk);
        chk(lo, 3'b010);
        repeat (16) @(posedge sys_clk);
        // Read-only bits are written as ones and must not stick.
        xfer(1'b1, SPP_CTRL_ADDR, 8'hff);
        xfer(1'b0, SPP_CTRL_ADDR, 8'h00);
        chk(rd & 32'hfe, 32'h2e);
        repeat (PC + 4) @(posedge sys_clk);
        rdchk(8'h3f);
        xfer(1'b1, SPP_CTRL_ADDR, 8'h28);
        repeat (16) @(posedge sys_clk);
        xfer(1'b1, SPP_CTRL_ADDR, 8'h2c);
        repeat (PC + 4) @(posedge sys_clk);
        rdchk(8'h3c);
        // A write without byte lane 0 must neither store nor clear ready.
        byte0_en = 1'b0;
        xfer(1'b1, SPP_CTRL_ADDR, 8'h00);
        byte0_en = 1'b1;
        rdchk(8'h3c);
        // Clearing the mode bit gives the port back.
        xfer(1'b1, SPP_CTRL_ADDR, 8'h00);
        repeat (4) @(posedge sys_clk);
        chk({req_n, cs_oe, loe}, 5'h10);
        xfer(1'b0, SPP_CTRL_ADDR + 10'h004, 8'h00);
        chk(rd, 32'h0);
        results();
    end
endmodule
